// [ptc_pkg.sv]
// constants and register map of the precision time clock control block
package ptc_pkg;

  // register indices; byte address is four times the index
  localparam logic [13:0] CTRL_IDX     = 14'h0500;
  localparam logic [13:0] PHASE_IDX    = 14'h0502;
  localparam logic [13:0] NS_HI_IDX    = 14'h0504;
  localparam logic [13:0] NS_LO_IDX    = 14'h0506;
  localparam logic [13:0] SEC_HI_IDX   = 14'h0508;
  localparam logic [13:0] SEC_LO_IDX   = 14'h050a;
  localparam logic [13:0] RATE_HI_IDX  = 14'h050c;
  localparam logic [13:0] RATE_LO_IDX  = 14'h050e;

  // control register fields
  localparam int CTRL_FREQ_DIS  = 15;
  localparam int CTRL_STEP      = 6;
  localparam int CTRL_STEP_DIR  = 5;
  localparam int CTRL_READ      = 4;
  localparam int CTRL_LOAD      = 3;
  localparam int CTRL_CONT_ADJ  = 2;
  localparam int CTRL_ENABLE    = 1;
  localparam int CTRL_RESET     = 0;
  localparam logic [15:0] CTRL_WR_MASK = 16'h807f;
  localparam logic [15:0] CTRL_SC_MASK = 16'h0059;

  // rate high word fields
  localparam int RATE_DIR       = 15;
  localparam int RATE_TEMP      = 14;
  localparam int RATE_HI_MSB    = 13;

  // reset values
  localparam logic [15:0] CTRL_RST  = 16'h0000;
  localparam logic [2:0]  PHASE_RST = 3'h0;
  localparam logic [15:0] WORD_RST  = 16'h0000;

  // timing
  localparam int CLK_PERIOD_NS  = 8;
  localparam int TICK_PERIOD_NS = 40;
  localparam int PHASE_COUNT    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [2:0]  PHASE_LAST = 3'(PHASE_COUNT - 1);
  localparam logic [31:0] NS_PER_SEC = 32'h3b9a_ca00;
  localparam logic [5:0]  TICK_NS    = 6'(TICK_PERIOD_NS);

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [ptc_time_if.sv]
// control and time signals between the register front end and the clock core
`timescale 1ns/1ps
interface ptc_time_if;
  logic        enable;
  logic        clk_reset;
  logic        load;
  logic [2:0]  load_phase;
  logic [31:0] load_ns;
  logic [31:0] load_sec;
  logic        step;
  logic        step_dir;
  logic [31:0] step_ns;
  logic        adj_en;
  logic        rate_dir;
  logic [29:0] rate;
  logic [2:0]  phase;
  logic [31:0] ns;
  logic [31:0] sec;

  modport ctl
  (
    output enable, clk_reset, load, load_phase, load_ns, load_sec,
    output step, step_dir, step_ns, adj_en, rate_dir, rate,
    input  phase, ns, sec
  );

  modport core
  (
    input  enable, clk_reset, load, load_phase, load_ns, load_sec,
    input  step, step_dir, step_ns, adj_en, rate_dir, rate,
    output phase, ns, sec
  );
endinterface

// [ptc_rtc_core.sv]
// running real-time clock: phase divider, sub-ns fraction, ns and seconds
`timescale 1ns/1ps
module ptc_rtc_core
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control and time
  ptc_time_if.core tif
);

  typedef struct packed
  {
    logic [2:0]  phase;
    logic [29:0] frac;
    logic [31:0] ns;
    logic [31:0] sec;
  } ptc_core_state_t;

  ptc_core_state_t st;
  ptc_core_state_t next_st;

  logic [30:0] frac_sum;
  logic [5:0]  inc;
  logic [32:0] ns_sum;
  logic        tick;

  always_comb
  begin
    next_st  = st;
    frac_sum = {1'b0, st.frac};
    inc      = ptc_pkg::TICK_NS;
    ns_sum   = {1'b0, st.ns};
    tick     = tif.enable && (st.phase >= ptc_pkg::PHASE_LAST);
    if (tif.enable)
    begin
      // 8 ns phases, invalid codes fall back to zero
      next_st.phase = tick ? 3'h0 : st.phase + 3'h1;
    end
    if (tick)
    begin
      if (tif.adj_en)
      begin
        if (tif.rate_dir)
        begin
          frac_sum = {1'b0, st.frac} + {1'b0, tif.rate};
          inc      = frac_sum[30] ? ptc_pkg::TICK_NS + 6'h1 : ptc_pkg::TICK_NS;
        end
        else
        begin
          frac_sum = {1'b0, st.frac} - {1'b0, tif.rate};
          inc      = frac_sum[30] ? ptc_pkg::TICK_NS - 6'h1 : ptc_pkg::TICK_NS;
        end
        next_st.frac = frac_sum[29:0];
      end
      ns_sum = {1'b0, st.ns} + {27'h0, inc};
      if (ns_sum >= {1'b0, ptc_pkg::NS_PER_SEC})
      begin
        ns_sum      = ns_sum - {1'b0, ptc_pkg::NS_PER_SEC};
        next_st.sec = st.sec + 32'h1;
      end
      next_st.ns = ns_sum[31:0];
    end
    if (tif.step)
    begin
      if (tif.step_dir)
      begin
        ns_sum = {1'b0, next_st.ns} + {1'b0, tif.step_ns};
        if (ns_sum >= {1'b0, ptc_pkg::NS_PER_SEC})
        begin
          ns_sum      = ns_sum - {1'b0, ptc_pkg::NS_PER_SEC};
          next_st.sec = next_st.sec + 32'h1;
        end
      end
      else if (next_st.ns >= tif.step_ns)
      begin
        ns_sum = {1'b0, next_st.ns} - {1'b0, tif.step_ns};
      end
      else
      begin
        ns_sum = {1'b0, next_st.ns} + {1'b0, ptc_pkg::NS_PER_SEC}
                 - {1'b0, tif.step_ns};
        next_st.sec = next_st.sec - 32'h1;
      end
      next_st.ns = ns_sum[31:0];
    end
    if (tif.load)
    begin
      next_st.phase = tif.load_phase;
      next_st.ns    = tif.load_ns;
      next_st.sec   = tif.load_sec;
      next_st.frac  = 30'h0;
    end
    if (tif.clk_reset)
    begin
      next_st = '0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign tif.phase = st.phase;
  assign tif.ns    = st.ns;
  assign tif.sec   = st.sec;

endmodule

// [ptc_clock_control.sv]
// precision time clock control: axi4-lite registers around the clock core
`timescale 1ns/1ps
module ptc_clock_control
#(
  parameter int ADDR_W = 16
)
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // write address channel
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output      logic              s_axi_awready,
  // write data channel
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output      logic              s_axi_wready,
  // write response channel
  output      logic [1:0]        s_axi_bresp,
  output      logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // read address channel
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output      logic              s_axi_arready,
  // read data channel
  output      logic [31:0]       s_axi_rdata,
  output      logic [1:0]        s_axi_rresp,
  output      logic              s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  typedef struct packed
  {
    logic              aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_held;
    logic [15:0]       w_data;
    logic [1:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [15:0]       rdata;
    logic [1:0]        rresp;
    logic [15:0]       ctrl;
    logic [2:0]        phase;
    logic [15:0]       ns_hi;
    logic [15:0]       ns_lo;
    logic [15:0]       sec_hi;
    logic [15:0]       sec_lo;
    logic [15:0]       rate_hi;
    logic [15:0]       rate_lo;
  } ptc_top_state_t;

  ptc_top_state_t st;
  ptc_top_state_t next_st;

  ptc_time_if tif ();

  ptc_rtc_core u_core
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tif     (tif.core)
  );

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16
  (
    input logic [15:0] old_v,
    input logic [15:0] new_v,
    input logic [1:0]  strb
  );
    logic [15:0] r;
    r = old_v;
    if (strb[0])
      r[7:0] = new_v[7:0];
    if (strb[1])
      r[15:8] = new_v[15:8];
    return r;
  endfunction

  // word index of a byte address
  function automatic logic [13:0] word_idx
  (
    input logic [ADDR_W-1:0] addr
  );
    logic [31:0] wide;
    wide = 32'(addr);
    return wide[15:2];
  endfunction

  // register hookup to the core; self-clearing bits act for one cycle
  always_comb
  begin
    tif.enable     = st.ctrl[ptc_pkg::CTRL_ENABLE];
    tif.clk_reset  = st.ctrl[ptc_pkg::CTRL_RESET];
    tif.load       = st.ctrl[ptc_pkg::CTRL_LOAD];
    tif.load_phase = st.phase;
    tif.load_ns    = {st.ns_hi, st.ns_lo};
    tif.load_sec   = {st.sec_hi, st.sec_lo};
    tif.step       = st.ctrl[ptc_pkg::CTRL_STEP];
    tif.step_dir   = st.ctrl[ptc_pkg::CTRL_STEP_DIR];
    tif.step_ns    = {st.ns_hi, st.ns_lo};
    tif.adj_en     = st.ctrl[ptc_pkg::CTRL_CONT_ADJ];
    tif.rate_dir   = st.rate_hi[ptc_pkg::RATE_DIR];
    tif.rate       = {st.rate_hi[ptc_pkg::RATE_HI_MSB:0], st.rate_lo};
  end

  logic [13:0] w_idx;
  logic [13:0] r_idx;
  logic        w_fire;
  logic        ar_fire;
  logic        w_hit;
  logic [15:0] w_val;
  logic [1:0]  w_lanes;

  assign s_axi_awready = !st.aw_held && !st.bvalid;
  assign s_axi_wready  = !st.w_held && !st.bvalid;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rresp   = st.rresp;
  assign s_axi_rdata   = {16'h0, st.rdata};

  always_comb
  begin
    next_st = st;
    w_idx   = word_idx(st.aw_addr);
    r_idx   = word_idx(s_axi_araddr);
    w_fire  = st.aw_held && st.w_held && !st.bvalid;
    ar_fire = s_axi_arvalid && !st.rvalid;
    w_hit   = 1'b0;
    w_val   = st.w_data;
    w_lanes = st.w_strb;

    // capture address and data in either order
    if (s_axi_awvalid && !st.aw_held && !st.bvalid)
    begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_held && !st.bvalid)
    begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata[15:0];
      next_st.w_strb = s_axi_wstrb[1:0];
    end
    if (st.bvalid && s_axi_bready)
    begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && s_axi_rready)
    begin
      next_st.rvalid = 1'b0;
    end

    // self-clearing command bits drop after their one active cycle
    next_st.ctrl = st.ctrl & ~ptc_pkg::CTRL_SC_MASK;

    // coherent snapshot of the running time, all fields in one cycle
    if (st.ctrl[ptc_pkg::CTRL_READ])
    begin
      next_st.phase  = tif.phase;
      next_st.ns_hi  = tif.ns[31:16];
      next_st.ns_lo  = tif.ns[15:0];
      next_st.sec_hi = tif.sec[31:16];
      next_st.sec_lo = tif.sec[15:0];
    end

    // register write; a software write wins over self clear and snapshot
    if (w_fire)
    begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      w_hit           = 1'b1;
      case (w_idx)
        ptc_pkg::CTRL_IDX:
        begin
          next_st.ctrl = merge16(next_st.ctrl, w_val, w_lanes)
                         & ptc_pkg::CTRL_WR_MASK;
        end
        ptc_pkg::PHASE_IDX:
        begin
          // codes 5 to 7 are stored as written
          if (w_lanes[0])
            next_st.phase = w_val[2:0];
        end
        ptc_pkg::NS_HI_IDX:
          next_st.ns_hi = merge16(next_st.ns_hi, w_val, w_lanes);
        ptc_pkg::NS_LO_IDX:
          next_st.ns_lo = merge16(next_st.ns_lo, w_val, w_lanes);
        ptc_pkg::SEC_HI_IDX:
          next_st.sec_hi = merge16(next_st.sec_hi, w_val, w_lanes);
        ptc_pkg::SEC_LO_IDX:
          next_st.sec_lo = merge16(next_st.sec_lo, w_val, w_lanes);
        ptc_pkg::RATE_HI_IDX:
          next_st.rate_hi = merge16(next_st.rate_hi, w_val, w_lanes);
        ptc_pkg::RATE_LO_IDX:
          next_st.rate_lo = merge16(next_st.rate_lo, w_val, w_lanes);
        default:
          w_hit = 1'b0;
      endcase
      next_st.bresp = w_hit ? ptc_pkg::RESP_OKAY : ptc_pkg::RESP_SLVERR;
    end

    // register read
    if (ar_fire)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = ptc_pkg::RESP_OKAY;
      case (r_idx)
        ptc_pkg::CTRL_IDX:
          next_st.rdata = st.ctrl;
        ptc_pkg::PHASE_IDX:
          next_st.rdata = {13'h0, st.phase};
        ptc_pkg::NS_HI_IDX:
          next_st.rdata = st.ns_hi;
        ptc_pkg::NS_LO_IDX:
          next_st.rdata = st.ns_lo;
        ptc_pkg::SEC_HI_IDX:
          next_st.rdata = st.sec_hi;
        ptc_pkg::SEC_LO_IDX:
          next_st.rdata = st.sec_lo;
        ptc_pkg::RATE_HI_IDX:
          next_st.rdata = st.rate_hi;
        ptc_pkg::RATE_LO_IDX:
          next_st.rdata = st.rate_lo;
        default:
        begin
          next_st.rdata = 16'h0;
          next_st.rresp = ptc_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st         <= '0;
      st.ctrl    <= ptc_pkg::CTRL_RST;
      st.phase   <= ptc_pkg::PHASE_RST;
      st.ns_hi   <= ptc_pkg::WORD_RST;
      st.ns_lo   <= ptc_pkg::WORD_RST;
      st.sec_hi  <= ptc_pkg::WORD_RST;
      st.sec_lo  <= ptc_pkg::WORD_RST;
      st.rate_hi <= ptc_pkg::WORD_RST;
      st.rate_lo <= ptc_pkg::WORD_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule

// [ptc_clock_control_checker.sv]
// port assertions for the clock control register block
`timescale 1ns/1ps
module ptc_checker
#(
  parameter int ADDR_W = 16
)
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid
);
  logic [13:0] rd_idx;
  logic        rd_map;

  // index of the read in flight
  always_ff @(posedge aclk)
    if (!aresetn)
      rd_idx <= 14'h0;
    else if (s_axi_arvalid && s_axi_arready)
      rd_idx <= 14'(s_axi_araddr >> 2);

  assign rd_map = rd_idx[13:4] == 10'h050 && !rd_idx[0];

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence

  property p_wr_answer;
    s_wr_taken |=> s_wr_answer;
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("write answer not on time");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer not on time");
  property p_upper0;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0;
  endproperty
  a_upper0: assert property (p_upper0)
    else $error("upper read data not zero");
  property p_phase_bits;
    s_axi_rvalid && rd_idx == ptc_pkg::PHASE_IDX |->
      s_axi_rdata[15:3] == 13'h0;
  endproperty
  a_phase_bits: assert property (p_phase_bits)
    else $error("phase upper bits not zero");
  property p_ctrl_rsvd;
    s_axi_rvalid && rd_idx == ptc_pkg::CTRL_IDX |->
      s_axi_rdata[14:7] == 8'h0;
  endproperty
  a_ctrl_rsvd: assert property (p_ctrl_rsvd)
    else $error("control reserved bits set");
  property p_unmapped;
    s_axi_rvalid && !rd_map |->
      s_axi_rresp == ptc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");
  property p_mapped_ok;
    s_axi_rvalid && rd_map |-> s_axi_rresp == ptc_pkg::RESP_OKAY;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok)
    else $error("mapped read refused");
  property p_ready_rst;
    $rose(aresetn) |-> s_axi_awready && s_axi_wready && s_axi_arready;
  endproperty
  a_ready_rst: assert property (p_ready_rst)
    else $error("bus not ready after reset");
endmodule

bind ptc_clock_control ptc_checker #(.ADDR_W(ADDR_W)) u_chk
(
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid
);

// [tb_ptc.sv]
// self-checking bench for the clock control register block
`timescale 1ns/1ps
module tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0;
  logic [15:0] s_axi_araddr = 16'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, ns, sec, got;
  logic [2:0]  ph;
  int          fail_count = 0;
  int          samples_checked = 0;

  always #4 aclk = ~aclk;

  ptc_clock_control DUT
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic guard(input logic done);
    if (!done)
    begin
      fail_count++;
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [13:0] idx, input logic [15:0] d,
                    input logic [1:0] er = 2'h0);
    int         n;
    logic       aw_ok;
    logic       w_ok;
    logic       b_ok;
    logic [1:0] resp;
    n = 0;
    b_ok = 1'b0;
    resp = 2'h0;
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // readies looked at mid-cycle, acted on at the following edge
    while (!b_ok && n < 50)
    begin
      @(negedge aclk);
      aw_ok = s_axi_awready;
      w_ok  = s_axi_wready;
      b_ok  = s_axi_bvalid;
      resp  = s_axi_bresp;
      @(posedge aclk);
      n++;
      if (aw_ok)
        s_axi_awvalid <= 1'b0;
      if (w_ok)
        s_axi_wvalid <= 1'b0;
    end
    guard(b_ok);
    chk("bresp", {30'h0, resp}, {30'h0, er});
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [13:0] idx, output logic [31:0] d,
                    input logic [1:0] er = 2'h0);
    int         n;
    logic       ar_ok;
    logic       r_ok;
    logic [1:0] resp;
    n = 0;
    r_ok = 1'b0;
    resp = 2'h0;
    d = 32'h0;
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    // data taken mid-cycle, before the edge that consumes it
    while (!r_ok && n < 50)
    begin
      @(negedge aclk);
      ar_ok = s_axi_arready;
      r_ok  = s_axi_rvalid;
      d     = s_axi_rdata;
      resp  = s_axi_rresp;
      @(posedge aclk);
      n++;
      if (ar_ok)
        s_axi_arvalid <= 1'b0;
    end
    guard(r_ok);
    chk("rresp", {30'h0, resp}, {30'h0, er});
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rc(input logic [13:0] idx, input logic [31:0] exp,
                    input logic [1:0] er = 2'h0);
    rd(idx, got, er);
    chk("rdata", got, exp);
  endtask

  // snapshot the running time, keeping control bits c
  task automatic snap(input logic [15:0] c);
    wr(ptc_pkg::CTRL_IDX, c | 16'h0010);
    rd(ptc_pkg::PHASE_IDX, got);
    ph = got[2:0];
    rd(ptc_pkg::NS_HI_IDX, got);
    ns[31:16] = got[15:0];
    rd(ptc_pkg::NS_LO_IDX, got);
    ns[15:0] = got[15:0];
    rd(ptc_pkg::SEC_HI_IDX, got);
    sec[31:16] = got[15:0];
    rd(ptc_pkg::SEC_LO_IDX, got);
    sec[15:0] = got[15:0];
  endtask

  task automatic load(input logic [2:0] p, input logic [31:0] n,
                      input logic [31:0] s);
    wr(ptc_pkg::PHASE_IDX, {13'h0, p});
    wr(ptc_pkg::NS_HI_IDX, n[31:16]);
    wr(ptc_pkg::NS_LO_IDX, n[15:0]);
    wr(ptc_pkg::SEC_HI_IDX, s[31:16]);
    wr(ptc_pkg::SEC_LO_IDX, s[15:0]);
    wr(ptc_pkg::CTRL_IDX, 16'h0008);
  endtask

  task automatic t_regs();
    for (int i = 0; i < 8; i++)
      rc(14'(ptc_pkg::CTRL_IDX + 2 * i), 32'h0);
    wr(ptc_pkg::NS_HI_IDX, 16'h1234);
    wr(ptc_pkg::SEC_LO_IDX, 16'habcd);
    rc(ptc_pkg::NS_HI_IDX, 32'h1234);
    rc(ptc_pkg::SEC_LO_IDX, 32'habcd);
    wr(ptc_pkg::PHASE_IDX, 16'hfffc);
    rc(ptc_pkg::PHASE_IDX, 32'h0004);
    wr(ptc_pkg::CTRL_IDX, 16'h7f80);
    rc(ptc_pkg::CTRL_IDX, 32'h0);
    wr(14'h0520, 16'h5555, ptc_pkg::RESP_SLVERR);
    rc(14'h0520, 32'h0, ptc_pkg::RESP_SLVERR);
    $display("test regs done");
  endtask

  task automatic t_load_step();
    load(3'h2, 32'd1000, 32'd10);
    snap(16'h0);
    chk("phase", {29'h0, ph}, 32'h2);
    chk("ns", ns, 32'd1000);
    chk("sec", sec, 32'd10);
    rc(ptc_pkg::CTRL_IDX, 32'h0);
    wr(ptc_pkg::NS_LO_IDX, 16'd300);
    wr(ptc_pkg::CTRL_IDX, 16'h0060);
    snap(16'h0);
    chk("ns", ns, 32'd1300);
    wr(ptc_pkg::NS_LO_IDX, 16'd500);
    wr(ptc_pkg::CTRL_IDX, 16'h0040);
    repeat (20) @(posedge aclk);
    snap(16'h0);
    chk("ns", ns, 32'd800);
    chk("sec", sec, 32'd10);
    $display("test load step done");
  endtask

  task automatic t_count_reset();
    load(3'h0, 32'h3b9a_c9d8, 32'd5);
    wr(ptc_pkg::CTRL_IDX, 16'h0002);
    repeat (30) @(posedge aclk);
    snap(16'h0002);
    chk("ns mod", ns % 40, 32'h0);
    chk("ns low", {31'h0, ns < 400}, 32'h1);
    chk("sec", sec, 32'd6);
    chk("phase ok", {31'h0, ph <= 3'h4}, 32'h1);
    wr(ptc_pkg::CTRL_IDX, 16'h0001);
    snap(16'h0);
    chk("rst ns", ns, 32'h0);
    chk("rst sec", sec, 32'h0);
    chk("rst phase", {29'h0, ph}, 32'h0);
    rc(ptc_pkg::CTRL_IDX, 32'h0);
    $display("test count reset done");
  endtask

  task automatic t_adjust();
    for (int d = 0; d < 2; d++)
    begin
      load(3'h0, 32'h0, 32'h0);
      wr(ptc_pkg::RATE_LO_IDX, 16'h0);
      wr(ptc_pkg::RATE_HI_IDX, {d[0], 15'h3fff});
      wr(ptc_pkg::CTRL_IDX, 16'h0006);
      repeat (60) @(posedge aclk);
      wr(ptc_pkg::CTRL_IDX, 16'h0);
      snap(16'h0);
      chk("ticked", {31'h0, ns > 200}, 32'h1);
      if (d == 1)
        chk("add", (ns + 1) % 41, 32'h0);
      else
        chk("sub", ns % 39, 32'h0);
    end
    $display("test adjust done");
  endtask

  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_load_step();
    t_count_reset();
    t_adjust();
    report_and_stop();
  end
endmodule
